// ===== include/clp_defines.svh
// Offsets, field positions, reset values and timing counts for the cache lock/flush/partition block
// Functional notes
// - Lock set or clear in user mode without user lock enable raises a locking exception.
// - Locking exception suppresses the instruction and takes a data storage interrupt.
// - save_restore_0 gets the effective address of the faulting instruction.
// - save_restore_1 gets the whole machine_state value at interrupt time.
// - machine_state keeps critical, machine check and debug enables; other bits clear.
// - data_lock_flag set for data lock set, store lock set or data lock clear.
// - instruction_lock_flag set for instruction lock set or instruction lock clear.
// - All other syndrome bits cleared on a locking exception.
// - Fetch resumes at vector prefix high bits, offset bits 48-59, four zeros.
// - direct_flush_available reads as one.
// - Flush write acts on the line picked by set and way, no tag compare.
// - flush_command picks the kind of flush or invalidate.
// - Direct flush touches only the data or unified L1 cache.
// - way_instr_disable masks ways 0-3 for instruction refills.
// - extra_way_instr_disable masks ways 4 and above for instruction refills.
// - way_data_disable masks ways 0-3 for data refills.
// - extra_way_data_disable masks ways 4 and above for data refills.
// - way_access_mode chooses lookup in all ways or only partitioned ways.
// - way_partition_available reports the partitioning facility.
// - Lock set hit sets the lock bit regardless of way disables; no replacement.
// - Lock set miss may only pick ways enabled for its access type.
// - Overlock is reported even when fewer than eight lines are locked.
// - All usable ways locked: no lock, and lock_overflow set for primary target.
`ifndef CLP_DEFINES_SVH
`define CLP_DEFINES_SVH
`define CLP_ADDR_CFG       32'h0000_0000
`define CLP_ADDR_CSR       32'h0000_0004
`define CLP_ADDR_FLUSH     32'h0000_0008
`define CLP_ADDR_SAVE_RESTORE_0      32'h0000_000C
`define CLP_ADDR_SAVE_RESTORE_1      32'h0000_0010
`define CLP_ADDR_SYND      32'h0000_0014
`define CLP_ADDR_MSR       32'h0000_0018
`define CLP_ADDR_VPFX      32'h0000_001C
`define CLP_ADDR_VOFF2     32'h0000_0020
`define CLP_ADDR_VPFX_HI   32'h0000_0024
`define CLP_ADDR_RESUME    32'h0000_0028
`define CLP_ADDR_RESUME_HI 32'h0000_002C
`define CLP_CFG_DFA_BIT    0
`define CLP_CFG_WPA_BIT    1
`define CLP_CSR_WID_LSB    0
`define CLP_CSR_EXTRA_WAY_INSTR_DISABLE_BIT   4
`define CLP_CSR_WDD_LSB    8
`define CLP_CSR_EXTRA_WAY_DATA_DISABLE_BIT   12
`define CLP_CSR_WAM_BIT    16
`define CLP_CSR_LO_BIT     17
`define CLP_FL_SET_LSB     0
`define CLP_FL_WAY_LSB     8
`define CLP_FL_CMD_LSB     12
`define CLP_MSR_CE_BIT     14
`define CLP_MSR_ME_BIT     12
`define CLP_MSR_DE_BIT     9
`define CLP_MSR_PR_BIT     17
`define CLP_MSR_USER_CACHE_LOCK_ENABLE_BIT   26
`define CLP_SYND_DLK_BIT   2
`define CLP_SYND_ILK_BIT   1
`define CLP_MSR_KEEP       32'h0000_5200
`define CLP_MSR_RESET      32'h0000_0000
`define CLP_CSR_RESET      32'h0000_0000
`define CLP_WB_CYCLES      4'h4
`endif

// ===== include/clp_pkg.sv
// Types for the cache lock/flush/partition block
package clp_pkg;
  typedef enum logic [4:0] {
    CLP_IDLE   = 5'b00001,
    CLP_WBACK  = 5'b00010,
    CLP_INVAL  = 5'b00100,
    CLP_LOCKLK = 5'b01000,
    CLP_DONE   = 5'b10000
  } clp_state_e;
  typedef enum logic [1:0] {
    CLP_CMD_INV  = 2'h0,
    CLP_CMD_WB   = 2'h1,
    CLP_CMD_WBI  = 2'h2,
    CLP_CMD_NONE = 2'h3
  } clp_cmd_e;
  typedef enum logic [2:0] {
    CLP_OP_DTLS   = 3'h0,
    CLP_OP_DTSTLS = 3'h1,
    CLP_OP_DLC    = 3'h2,
    CLP_OP_ITLS   = 3'h3,
    CLP_OP_ILC    = 3'h4
  } clp_op_e;
  typedef struct packed {
    logic        valid;
    clp_op_e     op;
    logic [63:0] ea;
    logic        hit;
    logic [2:0]  hitWay;
    logic [7:0]  lockedWays;
    logic        primary;
  } clp_lockreq_s;
  typedef struct packed {
    logic        valid;
    logic        lockSet;
    logic        lockClear;
    logic [6:0]  set;
    logic [2:0]  way;
  } clp_lockact_s;
  typedef struct packed {
    logic        valid;
    logic        writeBack;
    logic        invalidate;
    logic [6:0]  set;
    logic [2:0]  way;
  } clp_flushact_s;
  typedef struct packed {
    logic        taken;
    logic [63:0] save_restore_0;
    logic [31:0] save_restore_1;
    logic [31:0] machine_state;
    logic [31:0] synd;
    logic [63:0] resume;
  } clp_intr_s;
  typedef struct packed {
    clp_state_e    state;
    logic [3:0]    wbCount;
    logic [31:0]   csr;
    logic [14:0]   flushReg;
    logic [31:0]   machine_state;
    logic [63:0]   save_restore_0;
    logic [31:0]   save_restore_1;
    logic [31:0]   synd;
    logic [63:0]   vecPrefix;
    logic [15:0]   vecOff2;
    logic          hready;
    logic [31:0]   hrdata;
    logic          dPhase;
    logic          dWrite;
    logic [7:0]    dAddr;
    clp_intr_s     intr;
    clp_lockact_s  lockAct;
    clp_flushact_s flushAct;
    logic [7:0]    refillMaskI;
    logic [7:0]    refillMaskD;
    logic [7:0]    lookupMaskI;
    logic [7:0]    lookupMaskD;
  } clp_state_s;
endpackage : clp_pkg

// ===== src/clp_ctrl.sv
// Cache lock exception, direct flush and way partitioning control
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "clp_defines.svh"
module clp_ctrl
  import clp_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  input  wire clp_lockreq_s  lockReq,
  input  wire logic          lineDirty,
  input  wire logic          wbDone,
  output clp_intr_s          intrOut,
  output clp_lockact_s       lockAct,
  output clp_flushact_s      flushAct,
  output logic [7:0]         refillMaskI,
  output logic [7:0]         refillMaskD,
  output logic [7:0]         lookupMaskI,
  output logic [7:0]         lookupMaskD,
  output logic               flushBusy
);
  clp_state_s st;
  clp_state_s next_st;

  logic        isData;
  logic        isSet;
  logic        userDenied;
  logic [7:0]  allowMask;
  logic [7:0]  freeWays;
  logic [2:0]  pickWay;
  logic        pickOk;
  logic [31:0] rdVal;
  logic [31:0] cfgVal;
  logic [7:0]  maskI;
  logic [7:0]  maskD;
  logic [1:0]  cmd;

  always_comb begin
    isData = (lockReq.op == CLP_OP_DTLS) || (lockReq.op == CLP_OP_DTSTLS)
          || (lockReq.op == CLP_OP_DLC);
    isSet  = (lockReq.op == CLP_OP_DTLS) || (lockReq.op == CLP_OP_DTSTLS)
          || (lockReq.op == CLP_OP_ITLS);
    userDenied = lockReq.valid && !st.machine_state[`CLP_MSR_USER_CACHE_LOCK_ENABLE_BIT]
              && st.machine_state[`CLP_MSR_PR_BIT];
    // Disable bits are set-to-forbid, so enable is the complement
    maskI = ~{{4{st.csr[`CLP_CSR_EXTRA_WAY_INSTR_DISABLE_BIT]}}, st.csr[`CLP_CSR_WID_LSB +: 4]};
    maskD = ~{{4{st.csr[`CLP_CSR_EXTRA_WAY_DATA_DISABLE_BIT]}}, st.csr[`CLP_CSR_WDD_LSB +: 4]};
    allowMask = isData ? maskD : maskI;
    freeWays  = allowMask & ~lockReq.lockedWays;
    pickOk  = 1'b0;
    pickWay = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (freeWays[i]) begin
        pickOk  = 1'b1;
        pickWay = 3'(i);
      end
    end
    cfgVal = 32'h0000_0000;
    cfgVal[`CLP_CFG_DFA_BIT] = 1'b1;
    cfgVal[`CLP_CFG_WPA_BIT] = 1'b1;
    // Read data is picked in the address phase so it stands through the data phase
    case (haddr[7:0])
      8'(`CLP_ADDR_CFG):       rdVal = cfgVal;
      8'(`CLP_ADDR_CSR):       rdVal = st.csr;
      8'(`CLP_ADDR_FLUSH):     rdVal = {17'h0_0000, st.flushReg};
      8'(`CLP_ADDR_SAVE_RESTORE_0):      rdVal = st.save_restore_0[31:0];
      8'(`CLP_ADDR_SAVE_RESTORE_1):      rdVal = st.save_restore_1;
      8'(`CLP_ADDR_SYND):      rdVal = st.synd;
      8'(`CLP_ADDR_MSR):       rdVal = st.machine_state;
      8'(`CLP_ADDR_VPFX):      rdVal = st.vecPrefix[31:0];
      8'(`CLP_ADDR_VOFF2):     rdVal = {16'h0000, st.vecOff2};
      8'(`CLP_ADDR_VPFX_HI):   rdVal = st.vecPrefix[63:32];
      8'(`CLP_ADDR_RESUME):    rdVal = st.intr.resume[31:0];
      8'(`CLP_ADDR_RESUME_HI): rdVal = st.intr.resume[63:32];
      default:                 rdVal = 32'h0000_0000;
    endcase
    cmd = st.flushReg[`CLP_FL_CMD_LSB +: 2];
  end

  always_comb begin
    next_st = st;
    next_st.intr.taken      = 1'b0;
    next_st.lockAct.valid   = 1'b0;
    next_st.flushAct.valid  = 1'b0;
    next_st.hready          = 1'b1;
    // Bus data phase: write to the previously latched address
    if (st.dPhase) begin
      next_st.dPhase = 1'b0;
      if (st.dWrite) begin
        case (st.dAddr)
          8'(`CLP_ADDR_CSR): begin
            next_st.csr = hwdata;
            // Hardware overflow set wins over a software clear
            if (st.csr[`CLP_CSR_LO_BIT] && !hwdata[`CLP_CSR_LO_BIT]
                && st.state == CLP_LOCKLK) begin
              next_st.csr[`CLP_CSR_LO_BIT] = 1'b1;
            end
          end
          8'(`CLP_ADDR_FLUSH): begin
            next_st.flushReg = hwdata[14:0];
            if (st.state == CLP_IDLE) begin
              next_st.state = CLP_DONE;
            end
          end
          8'(`CLP_ADDR_MSR):     next_st.machine_state = hwdata;
          8'(`CLP_ADDR_SAVE_RESTORE_0):    next_st.save_restore_0[31:0] = hwdata;
          8'(`CLP_ADDR_SAVE_RESTORE_1):    next_st.save_restore_1 = hwdata;
          8'(`CLP_ADDR_SYND):    next_st.synd = hwdata;
          8'(`CLP_ADDR_VPFX):    next_st.vecPrefix[31:0] = hwdata;
          8'(`CLP_ADDR_VPFX_HI): next_st.vecPrefix[63:32] = hwdata;
          8'(`CLP_ADDR_VOFF2):   next_st.vecOff2 = hwdata[15:0];
          default: ;
        endcase
      end
    end
    if (hsel && hready && htrans[1]) begin
      next_st.dPhase = 1'b1;
      next_st.dWrite = hwrite;
      next_st.dAddr  = haddr[7:0];
      next_st.hready = 1'b1;
    end
    next_st.hrdata = (hsel && hready && htrans[1] && !hwrite) ? rdVal : st.hrdata;

    // Core lock instructions
    if (lockReq.valid) begin
      if (userDenied) begin
        // Instruction suppressed: no lock action is issued
        next_st.intr.taken = 1'b1;
        next_st.save_restore_0 = lockReq.ea;
        next_st.save_restore_1 = st.machine_state;
        next_st.machine_state  = st.machine_state & `CLP_MSR_KEEP;
        next_st.synd = 32'h0000_0000;
        next_st.synd[`CLP_SYND_DLK_BIT] = isData;
        next_st.synd[`CLP_SYND_ILK_BIT] = !isData;
        next_st.intr.resume = {st.vecPrefix[63:16], st.vecOff2[15:4], 4'h0};
      end else if (isSet && lockReq.hit) begin
        next_st.lockAct = '{valid: 1'b1, lockSet: 1'b1, lockClear: 1'b0,
                           set: lockReq.ea[12:6], way: lockReq.hitWay};
      end else if (isSet) begin
        if (pickOk) begin
          next_st.lockAct = '{valid: 1'b1, lockSet: 1'b1, lockClear: 1'b0,
                             set: lockReq.ea[12:6], way: pickWay};
        end else if (lockReq.primary) begin
          next_st.csr[`CLP_CSR_LO_BIT] = 1'b1;
        end
      end else if (lockReq.hit) begin
        next_st.lockAct = '{valid: 1'b1, lockSet: 1'b0, lockClear: 1'b1,
                           set: lockReq.ea[12:6], way: lockReq.hitWay};
      end
    end
    next_st.intr.save_restore_0 = next_st.save_restore_0;
    next_st.intr.save_restore_1 = next_st.save_restore_1;
    next_st.intr.machine_state  = next_st.machine_state;
    next_st.intr.synd = next_st.synd;

    // Direct flush sequencer, data or unified cache only
    case (st.state)
      CLP_IDLE: ;
      CLP_DONE: begin
        // Decode command once the flush register is settled
        if (cmd == CLP_CMD_INV) begin
          next_st.state = CLP_INVAL;
        end else if ((cmd == CLP_CMD_WB || cmd == CLP_CMD_WBI) && lineDirty) begin
          next_st.state = CLP_WBACK;
          next_st.wbCount = `CLP_WB_CYCLES;
          next_st.flushAct = '{valid: 1'b1, writeBack: 1'b1, invalidate: 1'b0,
                              set: st.flushReg[`CLP_FL_SET_LSB +: 7],
                              way: st.flushReg[`CLP_FL_WAY_LSB +: 3]};
        end else if (cmd == CLP_CMD_WBI) begin
          next_st.state = CLP_INVAL;
        end else begin
          next_st.state = CLP_IDLE;
        end
      end
      CLP_WBACK: begin
        if (wbDone) begin
          next_st.state = (cmd == CLP_CMD_WBI) ? CLP_INVAL : CLP_IDLE;
        end
      end
      CLP_INVAL: begin
        next_st.flushAct = '{valid: 1'b1, writeBack: 1'b0, invalidate: 1'b1,
                            set: st.flushReg[`CLP_FL_SET_LSB +: 7],
                            way: st.flushReg[`CLP_FL_WAY_LSB +: 3]};
        next_st.state = CLP_IDLE;
      end
      CLP_LOCKLK: next_st.state = CLP_IDLE;
      default: next_st.state = CLP_IDLE;
    endcase

    next_st.refillMaskI = maskI;
    next_st.refillMaskD = maskD;
    // Lookup uses all ways unless partitioned access is selected
    next_st.lookupMaskI = next_st.csr[`CLP_CSR_WAM_BIT] ? maskI : 8'hFF;
    next_st.lookupMaskD = next_st.csr[`CLP_CSR_WAM_BIT] ? maskD : 8'hFF;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.state <= CLP_IDLE;
      st.csr <= `CLP_CSR_RESET;
      st.machine_state <= `CLP_MSR_RESET;
      st.hready <= 1'b1;
      st.lookupMaskI <= 8'hFF;
      st.lookupMaskD <= 8'hFF;
      st.refillMaskI <= 8'hFF;
      st.refillMaskD <= 8'hFF;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    hreadyout   = st.hready;
    hrdata      = st.hrdata;
    hresp       = 1'b0;
    intrOut     = st.intr;
    lockAct     = st.lockAct;
    flushAct    = st.flushAct;
    refillMaskI = st.refillMaskI;
    refillMaskD = st.refillMaskD;
    lookupMaskI = st.lookupMaskI;
    lookupMaskD = st.lookupMaskD;
    flushBusy   = (st.state != CLP_IDLE);
  end

  a_deny_intr: assert property (@(posedge ref_clk) disable iff (reset)
    userDenied |=> intrOut.taken) else $error("denied lock did not interrupt");
  a_deny_nolock: assert property (@(posedge ref_clk) disable iff (reset)
    userDenied |=> !lockAct.valid) else $error("denied lock reached cache");
  a_save_restore_0_load: assert property (@(posedge ref_clk) disable iff (reset)
    userDenied |=> intrOut.save_restore_0 == $past(lockReq.ea)) else $error("save_restore_0 wrong");
  a_save_restore_1_load: assert property (@(posedge ref_clk) disable iff (reset)
    userDenied |=> intrOut.save_restore_1 == $past(st.machine_state)) else $error("save_restore_1 wrong");
  a_msr_keep: assert property (@(posedge ref_clk) disable iff (reset)
    userDenied |=> (st.machine_state & ~`CLP_MSR_KEEP) == 32'h0000_0000) else $error("msr not cleared");
  a_synd_flag: assert property (@(posedge ref_clk) disable iff (reset)
    userDenied |=> st.synd == ($past(isData) ? 32'h0000_0004 : 32'h0000_0002))
    else $error("syndrome wrong");
  a_resume_addr: assert property (@(posedge ref_clk) disable iff (reset)
    userDenied |=> intrOut.resume[3:0] == 4'h0 && intrOut.resume[15:4] == st.vecOff2[15:4])
    else $error("resume address wrong");
  a_lock_allowed: assert property (@(posedge ref_clk) disable iff (reset)
    lockReq.valid && !userDenied && isSet && !lockReq.hit && pickOk
    |=> lockAct.lockSet && $past(allowMask[pickWay])) else $error("lock in disabled way");
  a_wb_before_inv: assert property (@(posedge ref_clk) disable iff (reset)
    st.state == CLP_WBACK && !wbDone |=> !flushAct.invalidate) else $error("early invalidate");
endmodule : clp_ctrl

// ===== tb/clp_cache_model.sv
// Cache array model that answers direct flush requests
`timescale 1ns/1ps
module clp_cache_model
  import clp_pkg::*;
#(
  parameter int WB_LAT = 3
)(
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire clp_flushact_s flushAct,
  input  wire logic          markDirty,
  output logic               lineDirty,
  output logic               wbDone
);
  int cnt;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lineDirty <= 1'b0;
      wbDone    <= 1'b0;
      cnt       <= 0;
    end else begin
      wbDone <= 1'b0;
      if (markDirty) begin
        lineDirty <= 1'b1;
      end
      // Write-back clears the dirty flag only once it has really finished
      if (flushAct.valid && flushAct.writeBack) begin
        cnt <= WB_LAT;
      end else if (cnt == 1) begin
        wbDone    <= 1'b1;
        lineDirty <= 1'b0;
        cnt       <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
      if (flushAct.valid && flushAct.invalidate) begin
        lineDirty <= 1'b0;
      end
    end
  end
endmodule : clp_cache_model

// ===== tb/tb_top.sv
// Self-checking bench for the cache lock, flush and partition control
`timescale 1ns/1ps
`include "clp_defines.svh"
module tb_top;
  import clp_pkg::*;
  logic          ref_clk   = 1'b0;
  logic          reset     = 1'b1;
  logic          hsel      = 1'b0;
  logic [31:0]   haddr     = 32'h0;
  logic [1:0]    htrans    = 2'h0;
  logic          hwrite    = 1'b0;
  logic [2:0]    hsize     = 3'h2;
  logic [31:0]   hwdata    = 32'h0;
  logic          hready;
  logic          hreadyout;
  logic [31:0]   hrdata;
  logic          hresp;
  clp_lockreq_s  lockReq   = '0;
  logic          markDirty = 1'b0;
  logic          lineDirty;
  logic          wbDone;
  clp_intr_s     intrOut;
  clp_lockact_s  lockAct;
  clp_flushact_s flushAct;
  logic [7:0]    refillMaskI;
  logic [7:0]    refillMaskD;
  logic [7:0]    lookupMaskI;
  logic [7:0]    lookupMaskD;
  logic          flushBusy;
  logic [31:0]   rd;
  logic [63:0]   ea;
  int            bad_count   = 0;
  int            check_count = 0;

  always #2.5 ref_clk = ~ref_clk;
  assign hready = hreadyout;

  clp_ctrl u_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lockReq(lockReq),
    .lineDirty(lineDirty), .wbDone(wbDone), .intrOut(intrOut), .lockAct(lockAct),
    .flushAct(flushAct), .refillMaskI(refillMaskI), .refillMaskD(refillMaskD),
    .lookupMaskI(lookupMaskI), .lookupMaskD(lookupMaskD), .flushBusy(flushBusy));

  clp_cache_model u_cache (.ref_clk(ref_clk), .reset(reset), .flushAct(flushAct),
    .markDirty(markDirty), .lineDirty(lineDirty), .wbDone(wbDone));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic waitReady();
    do begin
      @(posedge ref_clk);
    end while (hready !== 1'b1);
  endtask : waitReady

  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask : bus

  // Issues one lock instruction and leaves the outcome ready to sample
  task automatic lock(input clp_op_e op, input logic [63:0] a, input logic hit,
                      input logic [2:0] hw, input logic [7:0] lw);
    lockReq <= '{valid: 1'b1, op: op, ea: a, hit: hit, hitWay: hw, lockedWays: lw,
                 primary: 1'b1};
    @(posedge ref_clk);
    lockReq.valid <= 1'b0;
    @(posedge ref_clk);
  endtask : lock

  task automatic waitFlush();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (flushAct.valid !== 1'b1 && n < 40);
    chk("flush wait", flushAct.valid, 1'b1);
  endtask : waitFlush

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk("masks", {refillMaskI, refillMaskD, lookupMaskI, lookupMaskD}, 64'hFFFF_FFFF);
    bus(1'b0, `CLP_ADDR_CFG, 32'h0);
    chk("cfg flush", rd[0], 1'b1);
    chk("cfg part", rd[1], 1'b1);
    chk("bus okay", {hresp, hreadyout}, 2'b01);
    bus(1'b0, 32'h0000_0040, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");

    bus(1'b1, `CLP_ADDR_CSR, 32'h0001_0A15);
    repeat (2) @(posedge ref_clk);
    chk("refill i", refillMaskI, 8'h0A);
    chk("refill d", refillMaskD, 8'hF5);
    chk("lookup part", {lookupMaskI, lookupMaskD}, 16'h0AF5);
    bus(1'b1, `CLP_ADDR_CSR, 32'h0000_0A15);
    repeat (2) @(posedge ref_clk);
    chk("lookup all", {lookupMaskI, lookupMaskD}, 16'hFFFF);
    $display("test partition done");

    bus(1'b1, `CLP_ADDR_VPFX, 32'h9ABC_DEF0);
    bus(1'b1, `CLP_ADDR_VPFX_HI, 32'h1234_5678);
    bus(1'b1, `CLP_ADDR_VOFF2, 32'h0000_0ABC);
    for (int i = 0; i < 5; i++) begin
      ea = 64'hFEDC_BA98_7654_3200 + 64'(i * 64);
      bus(1'b1, `CLP_ADDR_MSR, 32'h0002_5A81);
      lock(clp_op_e'(i), ea, 1'b1, 3'h1, 8'h00);
      chk("taken", intrOut.taken, 1'b1);
      chk("no lock", lockAct.valid, 1'b0);
      chk("save_restore_0", intrOut.save_restore_0, ea);
      chk("save_restore_1", intrOut.save_restore_1, 32'h0002_5A81);
      chk("msr", intrOut.machine_state, 32'h0000_5200);
      chk("synd", intrOut.synd, (i < 3) ? 32'h4 : 32'h2);
      chk("resume", intrOut.resume, 64'h1234_5678_9ABC_0AB0);
    end
    bus(1'b0, `CLP_ADDR_MSR, 32'h0);
    chk("msr reg", rd, 32'h0000_5200);
    $display("test lock exception done");

    bus(1'b1, `CLP_ADDR_MSR, 32'h0402_0000);
    bus(1'b1, `CLP_ADDR_CSR, 32'h0000_0F01);
    lock(CLP_OP_DTLS, 64'h1FC0, 1'b1, 3'h2, 8'h00);
    chk("hit lock", {lockAct.valid, lockAct.lockSet, lockAct.set, lockAct.way}, 12'hFFA);
    lock(CLP_OP_DTSTLS, 64'h40, 1'b0, 3'h0, 8'h10);
    chk("miss d", {lockAct.valid, lockAct.lockSet, lockAct.set, lockAct.way}, 12'hC0D);
    lock(CLP_OP_ITLS, 64'h80, 1'b0, 3'h0, 8'h00);
    chk("miss i", {lockAct.valid, lockAct.lockSet, lockAct.set, lockAct.way}, 12'hC11);
    lock(CLP_OP_DTLS, 64'hC0, 1'b0, 3'h0, 8'hF0);
    chk("overlock", lockAct.valid, 1'b0);
    bus(1'b0, `CLP_ADDR_CSR, 32'h0);
    chk("overflow", rd, 32'h0002_0F01);
    lock(CLP_OP_DLC, 64'h40, 1'b1, 3'h5, 8'h30);
    chk("clear", {lockAct.valid, lockAct.lockClear, lockAct.way}, 5'h1D);
    $display("test lock done");

    for (int c = 0; c < 3; c++) begin
      markDirty <= 1'b1;
      @(posedge ref_clk);
      markDirty <= 1'b0;
      bus(1'b1, `CLP_ADDR_FLUSH, {18'h0, 2'(c), 1'b0, 3'h3, 1'b0, 7'h55});
      waitFlush();
      chk("flush", {flushAct.writeBack, flushAct.invalidate, flushAct.set, flushAct.way},
          {c != 0, c == 0, 7'h55, 3'h3});
      if (c == 2) begin
        waitFlush();
        chk("wbi inval", {flushAct.invalidate, lineDirty}, 2'b10);
      end
      repeat (12) @(posedge ref_clk);
      chk("idle clean", {flushBusy, lineDirty}, 2'b00);
    end
    $display("test flush done");
    conclude();
  end
endmodule : tb_top
